// >>> design/sspiu_map.svh
// Offsets, field positions, codes and reset values of the command and task unit codec
`ifndef SSPIU_MAP_SVH
`define SSPIU_MAP_SVH

`define SSPIU_LUN_BYTES      9'h008
`define SSPIU_IDX_ATTR       9'h009
`define SSPIU_IDX_FUNC       9'h00A
`define SSPIU_IDX_DWORDS     9'h00B
`define SSPIU_IDX_CDB        9'h00C
`define SSPIU_IDX_TAG_HI     9'h00C
`define SSPIU_IDX_TAG_LO     9'h00D
`define SSPIU_UNIT_MIN_LEN   9'h01C
`define SSPIU_BASE_CDB_LEN   9'h010
`define SSPIU_CDB_MAX        9'h10C
`define SSPIU_FB_BIT         7
`define SSPIU_PRIO_HI        6
`define SSPIU_PRIO_LO        3
`define SSPIU_ATTR_HI        2
`define SSPIU_DW_HI          7
`define SSPIU_DW_LO          2

`define SSPIU_FN_ABORT_TASK  8'h01
`define SSPIU_FN_ABORT_SET   8'h02
`define SSPIU_FN_CLEAR_SET   8'h04
`define SSPIU_FN_LU_RESET    8'h08
`define SSPIU_FN_NEXUS_RESET 8'h10
`define SSPIU_FN_CLEAR_CA    8'h40
`define SSPIU_FN_QUERY_TASK  8'h80

`define SSPIU_RC_FN_UNSUP    8'h04
`define SSPIU_RC_BAD_LUN     8'h09

`define SSPIU_REG_FB_SIZE    8'h00
`define SSPIU_REG_LUN_COUNT  8'h04
`define SSPIU_REG_CMD_COUNT  8'h08
`define SSPIU_REG_TASK_COUNT 8'h0C
`define SSPIU_REG_ERR_COUNT  8'h10
`define SSPIU_REG_LAST_INFO  8'h14
`define SSPIU_RST_FB_SIZE    32'h0000_0000
`define SSPIU_RST_LUN_COUNT  16'h0001

`endif

// >>> design/sspiu_pkg.sv
// Types shared by the command and task unit codec
package sspiu_pkg;

    typedef enum logic [2:0] {
        ATTR_SIMPLE = 3'h0,
        ATTR_HEAD   = 3'h1,
        ATTR_ORDER  = 3'h2,
        ATTR_CA     = 3'h4
    } sspiu_attr_t;

    typedef enum logic [1:0] {
        PAYLOAD_NONE  = 2'h0,
        PAYLOAD_RESP  = 2'h1,
        PAYLOAD_SENSE = 2'h2
    } sspiu_payload_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_EMIT = 2'b11
    } sspiu_state_t;

    typedef struct packed {
        logic [63:0] lun;
        logic        first_burst;
        logic [31:0] first_burst_bytes;
        logic [3:0]  priority_level;
        logic        priority_applies;
        logic [2:0]  attribute;
        logic        attr_reserved;
        logic [5:0]  extra_command_block_dwords;
        logic [8:0]  cdb_bytes;
    } sspiu_cmd_t;

    typedef struct packed {
        logic [63:0] lun;
        logic [7:0]  function_code;
        logic        uses_tag;
        logic [15:0] managed_task_tag;
    } sspiu_task_t;

    typedef struct packed {
        sspiu_payload_t response_payload_kind;
        logic [7:0]     code;
    } sspiu_resp_t;

endpackage : sspiu_pkg

// >>> design/sspiu_codec.sv
// Receive-side decoder of command and task-management information units
// Function
// - Command unit: address, burst/priority/attribute byte, dword count, base and extra command block.
// - Burst enable set expects first-burst data of configured size; clear expects none.
// - Task priority orders a new task only among simple-attribute tasks.
// - Attribute codes: simple, head of queue, ordered, allegiance; others reserved.
// - Extra command block length counts four-byte dwords after sixteen base bytes.
// - Base and extra bytes form one block; bytes past its end ignored.
// - Command to missing logical unit gets incorrect-unit selection handling.
// - Task unit: address, function byte 10, managed tag bytes 12-13 big-endian.
// - Task to missing logical unit answers response data, incorrect-unit code, unless its function is nexus reset or reserved/unsupported.
// - Function codes 01h,02h,04h,08h,10h,40h,80h; all others reserved.
// - Reserved or unsupported function answers response data, not-supported code.
`timescale 1ns/1ps
`include "sspiu_map.svh"

module sspiu_codec #(
    parameter int CDB_DEPTH = 268
) (
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    input  wire logic                clk_en,
    input  wire logic                unit_valid,
    input  wire logic                unit_first,
    input  wire logic                unit_last,
    input  wire logic                unit_is_task,
    input  wire logic [7:0]          unit_byte,
    output logic                     unit_ready,
    output logic                     cmd_valid,
    output sspiu_pkg::sspiu_cmd_t    cmd_info,
    output logic                     lun_reject,
    output logic                     task_valid,
    output sspiu_pkg::sspiu_task_t   task_info,
    output logic                     resp_valid,
    output sspiu_pkg::sspiu_resp_t   resp_info,
    output logic                     frame_short,
    input  wire logic [8:0]          cdb_addr,
    output logic [7:0]               cdb_data,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata
);
    import sspiu_pkg::*;

    sspiu_state_t state_r;
    logic [8:0]   idx_r;
    logic         is_task_r;
    logic [63:0]  lun_r;
    logic [7:0]   attr_byte_r;
    logic [7:0]   func_r;
    logic [5:0]   dw_r;
    logic [15:0]  tag_r;
    logic [7:0]   cdb_mem [CDB_DEPTH];
    logic [31:0]  fb_size_r;
    logic [15:0]  lun_count_r;
    logic [15:0]  cmd_count_r;
    logic [15:0]  task_count_r;
    logic [15:0]  err_count_r;
    logic [21:0]  last_info_r;
    logic         take;
    logic [8:0]   cdb_end;
    logic         lun_ok;
    logic         fn_known;
    logic         too_short;
    logic [2:0]   attr_code;

    // Ready drops with the enable so the sender holds its byte instead of losing it
    assign unit_ready = clk_en && (state_r != ST_EMIT);
    assign take       = clk_en && unit_valid && unit_ready && (unit_first || state_r == ST_RECV);
    assign attr_code  = attr_byte_r[`SSPIU_ATTR_HI:0];
    // Bytes from index 12 up to this index belong to the command block; this index and later are padding
    assign cdb_end    = `SSPIU_UNIT_MIN_LEN + {1'b0, dw_r, 2'b00};
    // Only the low two address bytes name a unit; upper bytes must be zero
    assign lun_ok     = (lun_r[63:16] == 48'h0) && (lun_r[15:0] < lun_count_r);
    assign too_short  = is_task_r ? (idx_r < `SSPIU_UNIT_MIN_LEN) : (idx_r < cdb_end);

    always_comb begin
        unique case (func_r)
            `SSPIU_FN_ABORT_TASK, `SSPIU_FN_ABORT_SET, `SSPIU_FN_CLEAR_SET, `SSPIU_FN_LU_RESET,
            `SSPIU_FN_NEXUS_RESET, `SSPIU_FN_CLEAR_CA, `SSPIU_FN_QUERY_TASK: fn_known = 1'b1;
            default: fn_known = 1'b0;
        endcase
    end

    // Frame sequencing; idx_r ends holding the number of bytes received
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_r   <= ST_IDLE;
            idx_r     <= 9'h000;
            is_task_r <= 1'b0;
        end else if (clk_en) begin
            unique case (state_r)
                ST_IDLE, ST_RECV: begin
                    if (take) begin
                        idx_r   <= unit_first ? 9'h001 : (idx_r == 9'h1FF ? idx_r : idx_r + 9'h001);
                        state_r <= unit_last ? ST_EMIT : ST_RECV;
                        if (unit_first) begin
                            is_task_r <= unit_is_task;
                        end
                    end
                end
                ST_EMIT: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Field capture by byte position; reserved positions are never looked at
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lun_r       <= 64'h0000_0000_0000_0000;
            attr_byte_r <= 8'h00;
            func_r      <= 8'h00;
            dw_r        <= 6'h00;
            tag_r       <= 16'h0000;
        end else if (take) begin
            if (unit_first || idx_r < `SSPIU_LUN_BYTES) begin
                lun_r <= {(unit_first ? 56'h0 : lun_r[55:0]), unit_byte};
            end
            if (!unit_first) begin
                unique case (idx_r)
                    `SSPIU_IDX_ATTR:   attr_byte_r <= unit_byte;
                    `SSPIU_IDX_FUNC:   func_r <= unit_byte;
                    `SSPIU_IDX_DWORDS: dw_r <= unit_byte[`SSPIU_DW_HI:`SSPIU_DW_LO];
                    `SSPIU_IDX_TAG_HI: tag_r[15:8] <= unit_byte;
                    `SSPIU_IDX_TAG_LO: tag_r[7:0] <= unit_byte;
                    default: ;
                endcase
            end
        end
    end

    // Command block store; padding past the block end is dropped
    always_ff @(posedge ref_clk) begin
        if (take && !unit_first && !is_task_r && idx_r >= `SSPIU_IDX_CDB && idx_r < cdb_end) begin
            cdb_mem[idx_r - `SSPIU_IDX_CDB] <= unit_byte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cdb_data <= 8'h00;
        end else if (clk_en) begin
            cdb_data <= (cdb_addr < `SSPIU_CDB_MAX) ? cdb_mem[cdb_addr] : 8'h00;
        end
    end

    // Decode and answer one cycle after the last byte
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cmd_valid   <= 1'b0;
            cmd_info    <= '0;
            lun_reject  <= 1'b0;
            task_valid  <= 1'b0;
            task_info   <= '0;
            resp_valid  <= 1'b0;
            resp_info   <= '0;
            frame_short <= 1'b0;
        end else if (clk_en) begin
            cmd_valid   <= 1'b0;
            lun_reject  <= 1'b0;
            task_valid  <= 1'b0;
            resp_valid  <= 1'b0;
            frame_short <= 1'b0;
            if (state_r == ST_EMIT) begin
                if (too_short) begin
                    frame_short <= 1'b1;
                end else if (!is_task_r) begin
                    cmd_info.lun                        <= lun_r;
                    cmd_info.first_burst                <= attr_byte_r[`SSPIU_FB_BIT];
                    cmd_info.first_burst_bytes          <= attr_byte_r[`SSPIU_FB_BIT] ? fb_size_r : 32'h0000_0000;
                    cmd_info.priority_level             <= attr_byte_r[`SSPIU_PRIO_HI:`SSPIU_PRIO_LO];
                    cmd_info.priority_applies           <= (attr_code == ATTR_SIMPLE);
                    cmd_info.attribute                  <= attr_code;
                    cmd_info.attr_reserved              <= !(attr_code inside {ATTR_SIMPLE, ATTR_HEAD,
                                                             ATTR_ORDER, ATTR_CA});
                    cmd_info.extra_command_block_dwords <= dw_r;
                    cmd_info.cdb_bytes                  <= cdb_end - `SSPIU_IDX_CDB;
                    cmd_valid                           <= lun_ok;
                    lun_reject                          <= !lun_ok;
                end else if (!fn_known) begin
                    resp_valid <= 1'b1;
                    resp_info  <= '{response_payload_kind: PAYLOAD_RESP, code: `SSPIU_RC_FN_UNSUP};
                end else if (!lun_ok && func_r != `SSPIU_FN_NEXUS_RESET) begin
                    resp_valid <= 1'b1;
                    resp_info  <= '{response_payload_kind: PAYLOAD_RESP, code: `SSPIU_RC_BAD_LUN};
                end else begin
                    task_valid                 <= 1'b1;
                    task_info.lun              <= lun_r;
                    task_info.function_code    <= func_r;
                    task_info.uses_tag         <= (func_r == `SSPIU_FN_ABORT_TASK) ||
                                                  (func_r == `SSPIU_FN_QUERY_TASK);
                    task_info.managed_task_tag <= tag_r;
                end
            end
        end
    end

    // Software registers: burst size and unit count steer decoding
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fb_size_r   <= `SSPIU_RST_FB_SIZE;
            lun_count_r <= `SSPIU_RST_LUN_COUNT;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `SSPIU_REG_FB_SIZE) begin
                fb_size_r <= reg_wdata;
            end
            if (reg_addr == `SSPIU_REG_LUN_COUNT) begin
                lun_count_r <= reg_wdata[15:0];
            end
        end
    end

    // Event counters wrap; software takes differences
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cmd_count_r  <= 16'h0000;
            task_count_r <= 16'h0000;
            err_count_r  <= 16'h0000;
            last_info_r  <= 22'h00_0000;
        end else if (clk_en) begin
            if (cmd_valid) begin
                cmd_count_r <= cmd_count_r + 16'h0001;
                last_info_r <= {8'h00, cmd_info.extra_command_block_dwords, cmd_info.attribute,
                                cmd_info.priority_level, cmd_info.first_burst};
            end
            if (task_valid) begin
                task_count_r <= task_count_r + 16'h0001;
                last_info_r  <= {task_info.function_code, 14'h0000};
            end
            if (lun_reject || resp_valid || frame_short) begin
                err_count_r <= err_count_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    `SSPIU_REG_FB_SIZE:    reg_rdata <= fb_size_r;
                    `SSPIU_REG_LUN_COUNT:  reg_rdata <= {16'h0000, lun_count_r};
                    `SSPIU_REG_CMD_COUNT:  reg_rdata <= {16'h0000, cmd_count_r};
                    `SSPIU_REG_TASK_COUNT: reg_rdata <= {16'h0000, task_count_r};
                    `SSPIU_REG_ERR_COUNT:  reg_rdata <= {16'h0000, err_count_r};
                    `SSPIU_REG_LAST_INFO:  reg_rdata <= {10'h000, last_info_r};
                    default:               reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_burst_none;
        cmd_valid && !cmd_info.first_burst |-> cmd_info.first_burst_bytes == 32'h0000_0000;
    endproperty
    a_burst_none: assert property (p_burst_none) else $error("burst size given without enable");

    property p_burst_size;
        cmd_valid && cmd_info.first_burst |-> cmd_info.first_burst_bytes == fb_size_r;
    endproperty
    a_burst_size: assert property (p_burst_size) else $error("burst size differs from setting");

    property p_cdb_len;
        cmd_valid |-> cmd_info.cdb_bytes == 9'h010 + {1'b0, cmd_info.extra_command_block_dwords, 2'b00};
    endproperty
    a_cdb_len: assert property (p_cdb_len) else $error("command block length wrong");

    property p_prio;
        cmd_valid |-> cmd_info.priority_applies == (cmd_info.attribute == 3'h0);
    endproperty
    a_prio: assert property (p_prio) else $error("priority applied to non-simple task");

    property p_attr_rsv;
        cmd_valid |-> cmd_info.attr_reserved == (cmd_info.attribute inside {3'h3, 3'h5, 3'h6, 3'h7});
    endproperty
    a_attr_rsv: assert property (p_attr_rsv) else $error("attribute reservation flag wrong");

    property p_lun_excl;
        lun_reject && $past(clk_en) |-> !cmd_valid && $past(state_r) == ST_EMIT && !$past(lun_ok);
    endproperty
    a_lun_excl: assert property (p_lun_excl) else $error("bad unit not rejected cleanly");

    property p_resp_kind;
        resp_valid |-> resp_info.response_payload_kind == PAYLOAD_RESP && !task_valid;
    endproperty
    a_resp_kind: assert property (p_resp_kind) else $error("response lacks response data");

    property p_fn_code;
        clk_en && state_r == ST_EMIT && is_task_r && !too_short && !fn_known
            |=> resp_valid && resp_info.code == 8'h04;
    endproperty
    a_fn_code: assert property (p_fn_code) else $error("unsupported function not answered");

    property p_emit;
        take && unit_last |=> state_r == ST_EMIT ##1 (state_r == ST_IDLE || !$past(clk_en));
    endproperty
    a_emit: assert property (p_emit) else $error("decode did not follow last byte");

endmodule : sspiu_codec

// >>> tb/sspiu_initiator.sv
// Initiator-side model that streams one stored information unit into the codec
`timescale 1ns/1ps

module sspiu_initiator (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       start,
    input  wire logic       is_task,
    input  wire logic [8:0] len,
    input  wire logic       unit_ready,
    output logic            unit_valid,
    output logic            unit_first,
    output logic            unit_last,
    output logic            unit_is_task,
    output logic [7:0]      unit_byte
);
    logic [7:0] mem [0:299];
    logic [8:0] idx_r;

    // One unit of len bytes, whole or cut short, is sent per start
    // Frame header tags, unique per nexus over both unit kinds, are settled before this point
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            unit_valid   <= 1'b0;
            unit_first   <= 1'b0;
            unit_last    <= 1'b0;
            unit_is_task <= 1'b0;
            unit_byte    <= 8'h00;
            idx_r        <= 9'h000;
        end else if (!unit_valid && start) begin
            unit_valid   <= 1'b1;
            unit_first   <= 1'b1;
            unit_last    <= (len == 9'h001);
            unit_is_task <= is_task;
            unit_byte    <= mem[0];
            idx_r        <= 9'h001;
        end else if (unit_valid && unit_ready) begin
            unit_first <= 1'b0;
            if (unit_last) begin
                unit_valid <= 1'b0;
                unit_last  <= 1'b0;
                // Released line shows the inverse so a stale byte is never mistaken for data
                unit_byte  <= ~unit_byte;
            end else begin
                unit_last <= (idx_r == len - 9'h001);
                unit_byte <= mem[idx_r];
                idx_r     <= idx_r + 9'h001;
            end
        end
    end
endmodule : sspiu_initiator

// >>> tb/testbench.sv
// Self-checking bench for the command and task unit decoder
`timescale 1ns/1ps
`include "sspiu_map.svh"

module testbench;
    import sspiu_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, start = 1'b0, is_task = 1'b0;
    logic [8:0] len = 9'h000, cdb_addr = 9'h000;
    logic uv, uf, ul, ut, ur, cmd_valid, lun_reject, task_valid, resp_valid, frame_short;
    logic [7:0] ub, cdb_data, reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rd;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic clk_en = 1'b1, gate = 1'b0;
    sspiu_cmd_t cmd_info;
    sspiu_task_t task_info;
    sspiu_resp_t resp_info;
    int bad_count = 0, n_checks = 0, cycles = 0, kind;

    always #2 ref_clk = ~ref_clk;

    // While gate is set the enable toggles every cycle
    always @(posedge ref_clk) clk_en <= !gate || !clk_en;

    sspiu_initiator ini (.ref_clk(ref_clk), .nrst(nrst), .start(start), .is_task(is_task), .len(len),
        .unit_ready(ur), .unit_valid(uv), .unit_first(uf), .unit_last(ul), .unit_is_task(ut), .unit_byte(ub));

    sspiu_codec dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .unit_valid(uv), .unit_first(uf),
        .unit_last(ul), .unit_is_task(ut), .unit_byte(ub), .unit_ready(ur), .cmd_valid(cmd_valid),
        .cmd_info(cmd_info), .lun_reject(lun_reject), .task_valid(task_valid), .task_info(task_info),
        .resp_valid(resp_valid), .resp_info(resp_info), .frame_short(frame_short), .cdb_addr(cdb_addr),
        .cdb_data(cdb_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Cuts a hang short well above the thousand or so cycles the scenarios need
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            end_of_test();
        end
    end

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            bad_count = bad_count + 1;
        end
    endtask : chk

    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task reg_read(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : reg_read

    task cdb_check(input logic [8:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        cdb_addr <= a;
        @(posedge ref_clk);
        #1 chk("cdb_data", exp, cdb_data);
    endtask : cdb_check

    task fill_cmd(input logic [63:0] lun, input logic [7:0] b9, input logic [5:0] n);
        for (int i = 0; i < 8; i++) ini.mem[i] = lun[63-8*i -: 8];
        ini.mem[8]  = 8'hA5;
        ini.mem[9]  = b9;
        ini.mem[10] = 8'h5A;
        ini.mem[11] = {n, 2'b11};
        for (int i = 12; i < 300; i++) ini.mem[i] = 8'h24 + i[7:0];
    endtask : fill_cmd

    task fill_task(input logic [63:0] lun, input logic [7:0] fn);
        for (int i = 0; i < 8; i++) ini.mem[i] = lun[63-8*i -: 8];
        for (int i = 8; i < 28; i++) ini.mem[i] = 8'hC3;
        ini.mem[10] = fn;
        ini.mem[12] = 8'hBE;
        ini.mem[13] = 8'hEF;
    endtask : fill_task

    // kind: 1 command, 2 unit rejected, 3 task, 4 response, 5 short, 0 nothing
    task run_unit(input logic [8:0] n, input logic t);
        @(posedge ref_clk);
        start   <= 1'b1;
        is_task <= t;
        len     <= n;
        @(posedge ref_clk);
        start <= 1'b0;
        kind = 0;
        for (int c = 0; c < 400 && kind == 0; c++) begin
            @(posedge ref_clk);
            #1;
            if (cmd_valid === 1'b1) kind = 1;
            else if (lun_reject === 1'b1) kind = 2;
            else if (task_valid === 1'b1) kind = 3;
            else if (resp_valid === 1'b1) kind = 4;
            else if (frame_short === 1'b1) kind = 5;
        end
    endtask : run_unit

    task t_regs;
        reg_read(`SSPIU_REG_FB_SIZE);
        chk("fb_size reset", `SSPIU_RST_FB_SIZE, rd);
        reg_read(`SSPIU_REG_LUN_COUNT);
        chk("lun_count reset", 32'h0000_0001, rd);
        reg_read(8'h20);
        chk("unmapped read", 32'h0000_0000, rd);
        reg_write(`SSPIU_REG_FB_SIZE, 32'h0000_0200);
        reg_write(`SSPIU_REG_LUN_COUNT, 32'h0000_0004);
        reg_write(`SSPIU_REG_CMD_COUNT, 32'h0000_1234);
        reg_read(`SSPIU_REG_CMD_COUNT);
        chk("cmd_count read-only", 32'h0000_0000, rd);
    endtask : t_regs

    task t_cmd_burst;
        fill_cmd(64'h0000_0000_0000_0002, {1'b1, 4'h5, 3'h0}, 6'h02);
        run_unit(9'h024, 1'b0);
        chk("cmd kind", 1, kind);
        chk("lun", 32'h0000_0002, cmd_info.lun[31:0]);
        chk("first_burst", 1, cmd_info.first_burst);
        chk("first_burst_bytes", 32'h0000_0200, cmd_info.first_burst_bytes);
        chk("priority", 5, cmd_info.priority_level);
        chk("priority_applies", 1, cmd_info.priority_applies);
        chk("dwords", 2, cmd_info.extra_command_block_dwords);
        chk("cdb_bytes", 24, cmd_info.cdb_bytes);
        cdb_check(9'h000, 8'h30);
        cdb_check(9'h017, 8'h47);
        reg_read(`SSPIU_REG_LAST_INFO);
        chk("last_info cmd", 32'h0000_020B, rd);
    endtask : t_cmd_burst

    // Enable toggles every cycle; the stream must stall, not lose bytes
    task t_freeze;
        fill_cmd(64'h0000_0000_0000_0001, {1'b0, 4'h3, 3'h2}, 6'h01);
        @(posedge ref_clk);
        gate <= 1'b1;
        run_unit(9'h020, 1'b0);
        @(posedge ref_clk);
        gate <= 1'b0;
        chk("frozen cmd kind", 1, kind);
        chk("frozen attribute", 2, cmd_info.attribute);
        chk("frozen priority", 3, cmd_info.priority_level);
        chk("frozen priority_applies", 0, cmd_info.priority_applies);
        chk("frozen cdb_bytes", 20, cmd_info.cdb_bytes);
        cdb_check(9'h013, 8'h43);
    endtask : t_freeze

    task t_attr;
        for (int a = 0; a < 8; a++) begin
            fill_cmd(64'h0000_0000_0000_0003, {1'b0, 4'hA, a[2:0]}, 6'h00);
            run_unit(9'h01C, 1'b0);
            chk("cmd kind", 1, kind);
            chk("attribute", a, cmd_info.attribute);
            chk("attr_reserved", (a == 3 || a > 4), cmd_info.attr_reserved);
            chk("priority_applies", (a == 0), cmd_info.priority_applies);
            chk("first_burst_bytes", 0, cmd_info.first_burst_bytes);
        end
    endtask : t_attr

    task t_cmd_edge;
        fill_cmd(64'h0000_0000_0000_0004, 8'h00, 6'h00);
        run_unit(9'h01C, 1'b0);
        chk("missing unit kind", 2, kind);
        fill_cmd(64'h0001_0000_0000_0000, 8'h00, 6'h00);
        run_unit(9'h01C, 1'b0);
        chk("high lun kind", 2, kind);
        fill_cmd(64'h0000_0000_0000_0001, 8'h00, 6'h01);
        run_unit(9'h01C, 1'b0);
        chk("short cmd kind", 5, kind);
        fill_cmd(64'h0000_0000_0000_0001, 8'h00, 6'h00);
        run_unit(9'h028, 1'b0);
        chk("long cmd kind", 1, kind);
        chk("cdb_bytes", 16, cmd_info.cdb_bytes);
        fill_task(64'h0000_0000_0000_0001, `SSPIU_FN_ABORT_TASK);
        run_unit(9'h01B, 1'b1);
        chk("short task kind", 5, kind);
    endtask : t_cmd_edge

    task t_task_codes;
        logic [7:0] fn [0:10];
        logic known;
        fn = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80, 8'h20, 8'h00, 8'h03, 8'hFF};
        for (int i = 0; i < 11; i++) begin
            known = (i < 7);
            fill_task(64'h0000_0000_0000_0001, fn[i]);
            run_unit(9'h01C, 1'b1);
            chk("task kind", known ? 3 : 4, kind);
            if (known) begin
                chk("function_code", fn[i], task_info.function_code);
                chk("managed_task_tag", 16'hBEEF, task_info.managed_task_tag);
                chk("uses_tag", (fn[i] == 8'h01 || fn[i] == 8'h80), task_info.uses_tag);
            end else begin
                chk("payload", PAYLOAD_RESP, resp_info.response_payload_kind);
                chk("code", `SSPIU_RC_FN_UNSUP, resp_info.code);
            end
        end
    endtask : t_task_codes

    task t_task_lun;
        fill_task(64'h0000_0000_0000_0009, `SSPIU_FN_ABORT_TASK);
        run_unit(9'h01C, 1'b1);
        chk("bad lun kind", 4, kind);
        chk("payload", PAYLOAD_RESP, resp_info.response_payload_kind);
        chk("code", `SSPIU_RC_BAD_LUN, resp_info.code);
        fill_task(64'h0000_0000_0000_0009, `SSPIU_FN_NEXUS_RESET);
        run_unit(9'h01C, 1'b1);
        chk("nexus reset kind", 3, kind);
        fill_task(64'h0000_0000_0000_0009, 8'h20);
        run_unit(9'h01C, 1'b1);
        chk("order kind", 4, kind);
        chk("order code", `SSPIU_RC_FN_UNSUP, resp_info.code);
    endtask : t_task_lun

    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_cmd_burst();
        t_attr();
        t_cmd_edge();
        t_freeze();
        t_task_codes();
        t_task_lun();
        reg_read(`SSPIU_REG_CMD_COUNT);
        chk("cmd_count", 32'h0000_000B, rd);
        reg_read(`SSPIU_REG_TASK_COUNT);
        chk("task_count", 32'h0000_0008, rd);
        reg_read(`SSPIU_REG_ERR_COUNT);
        chk("err_count", 32'h0000_000A, rd);
        reg_read(`SSPIU_REG_LAST_INFO);
        chk("last_info task", 32'h0004_0000, rd);
        end_of_test();
    end
endmodule : testbench
